// [smac_pkg.sv]
package smac_pkg;

    // register byte offsets on the bus
    localparam int unsigned SMAC_AW = 8;
    localparam logic [7:0] SMAC_OFS_OPA = 8'h00;
    localparam logic [7:0] SMAC_OFS_OPB = 8'h04;
    localparam logic [7:0] SMAC_OFS_ACC = 8'h08;
    localparam logic [7:0] SMAC_OFS_RLO = 8'h0c;
    localparam logic [7:0] SMAC_OFS_RHI = 8'h10;
    localparam logic [7:0] SMAC_OFS_CTRL = 8'h14;
    localparam logic [7:0] SMAC_OFS_STAT = 8'h18;

    // control and status field positions
    localparam int unsigned SMAC_CTRL_OP_LSB = 0;
    localparam int unsigned SMAC_CTRL_OP_W = 5;
    localparam int unsigned SMAC_CTRL_COND_BIT = 8;
    localparam int unsigned SMAC_CTRL_START_BIT = 31;
    localparam int unsigned SMAC_STAT_Q_BIT = 0;
    localparam int unsigned SMAC_STAT_BUSY_BIT = 1;

    // reset values
    localparam logic [31:0] SMAC_RST_WORD = 32'h0000_0000;
    localparam logic [31:0] SMAC_RST_CTRL = 32'h0000_0100;

    typedef enum logic [4:0] {
        mac_half_low_low = 5'h00, mac_half_low_high = 5'h01,
        mac_half_high_low = 5'h02, mac_half_high_high = 5'h03,
        mac_word_by_low_half = 5'h04, mac_word_by_high_half = 5'h05,
        dual_mac_short = 5'h06, dual_mac_short_swapped = 5'h07,
        long_word_mac = 5'h08,
        long_dual_mac = 5'h0a, long_dual_mac_swapped = 5'h0b,
        long_half_mac_low_low = 5'h0c, long_half_mac_low_high = 5'h0d,
        long_half_mac_high_low = 5'h0e, long_half_mac_high_high = 5'h0f,
        dual_mul_sub_short = 5'h10, dual_mul_sub_short_swapped = 5'h11,
        long_dual_mul_sub = 5'h12, long_dual_mul_sub_swapped = 5'h13
    } smac_op_t;

    typedef enum logic [3:0] {
        KIND_NONE = 4'h0, KIND_HALF = 4'h1, KIND_WORD_HALF = 4'h2,
        KIND_DUAL_ADD = 4'h3, KIND_DUAL_SUB = 4'h4, KIND_LONG_WORD = 4'h5,
        KIND_LONG_HALF = 4'h6, KIND_LONG_DUAL_ADD = 4'h7, KIND_LONG_DUAL_SUB = 4'h8
    } smac_kind_t;

    typedef struct packed {
        smac_kind_t kind;
        logic x_hi;
        logic y_hi;
    } smac_dec_t;

    typedef struct packed {
        logic [15:0] x0;
        logic [15:0] y0;
        logic [15:0] x1;
        logic [15:0] y1;
    } smac_halves_t;

    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] hi;
        logic wr_lo;
        logic wr_hi;
        logic ovf;
    } smac_res_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [SMAC_AW-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } smac_wb_req_t;

    // bit 0 of the code picks the second-operand half or the swap
    function automatic smac_dec_t smac_decode(input logic [4:0] op);
        smac_dec_t d;
        d.kind = KIND_NONE;
        d.y_hi = op[0];
        case (op[4:1])
            4'h0, 4'h1: d.kind = KIND_HALF;
            4'h2: d.kind = KIND_WORD_HALF;
            4'h3: d.kind = KIND_DUAL_ADD;
            4'h4: d.kind = op[0] ? KIND_NONE : KIND_LONG_WORD;
            4'h5: d.kind = KIND_LONG_DUAL_ADD;
            4'h6, 4'h7: d.kind = KIND_LONG_HALF;
            4'h8: d.kind = KIND_DUAL_SUB;
            4'h9: d.kind = KIND_LONG_DUAL_SUB;
            default: d.kind = KIND_NONE;
        endcase
        d.x_hi = op[1] && (d.kind == KIND_HALF || d.kind == KIND_LONG_HALF);
        return d;
    endfunction

    // signed overflow of a 32-bit add
    function automatic logic smac_ovf32(input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
        return (a[31] == b[31]) && (s[31] != a[31]);
    endfunction

    function automatic logic [63:0] smac_sx64(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction

    function automatic logic [31:0] smac_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// [smac_half_pick.sv]
`timescale 1ns/10ps
module smac_half_pick (
    input wire logic [31:0] first_operand,
    input wire logic [31:0] second_operand,
    input wire smac_pkg::smac_dec_t dec,
    output smac_pkg::smac_halves_t halves
);
    import smac_pkg::*;

    logic [15:0] a_lo;
    logic [15:0] a_hi;
    logic [15:0] b_lo;
    logic [15:0] b_hi;

    assign a_lo = first_operand[15:0];
    assign a_hi = first_operand[31:16];
    assign b_lo = second_operand[15:0];
    assign b_hi = second_operand[31:16];

    // x0 and y0 take the picked halves; x1 is always the first high half and y1 the other second half
    always_comb begin
        halves.x0 = dec.x_hi ? a_hi : a_lo;
        halves.y0 = dec.y_hi ? b_hi : b_lo;
        halves.x1 = a_hi;
        halves.y1 = dec.y_hi ? b_lo : b_hi;
    end
endmodule

// [smac_wb_port.sv]
`timescale 1ns/10ps
module smac_wb_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire smac_pkg::smac_wb_req_t req,
    input wire logic [31:0] rd_word,
    output logic ack,
    output logic [31:0] dat_r,
    output logic wr_stb
);
    import smac_pkg::*;

    // one wait state, ack high for exactly one enabled cycle per request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack <= 1'b0;
        end else if (ce) begin
            ack <= req.cyc && req.stb && !ack;
        end
    end

    // read data is sampled together with raising ack so it is stable while ack stands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dat_r <= SMAC_RST_WORD;
        end else if (ce && req.cyc && req.stb && !ack) begin
            dat_r <= req.we ? SMAC_RST_WORD : rd_word;
        end
    end

    // write lands on the edge where the master samples ack
    assign wr_stb = ack && req.cyc && req.stb && req.we && ce;
endmodule

// [smac_unit.sv]
`timescale 1ns/10ps
// What this block does
// - half forms: picked signed halves multiplied, accumulate added, sum to result
// - low pick is bits 15..0, high pick bits 31..16, per operand
// - unpicked halfwords never influence the result
// - word-by-half: 48-bit product, top 32 bits plus accumulate, low 16 dropped
// - accumulate overflow in half or word-half forms sets sticky overflow
// - dual add: high by high plus low by low plus accumulate
// - swap pairs each first half with the opposite second half
// - short dual add forms leave every flag alone
// - long word form: 32x32 signed product added to 64-bit accumulator
// - long half forms: sign-extended 32-bit product added to 64-bit accumulator
// - long dual add forms: both products, per swap, added to 64-bit accumulator
// - low word holds bits 31..0, high word upper bits, both accumulate
// - long forms never touch a flag
// - dual subtract: low product minus high product, then accumulate added
// - long dual subtract: difference plus 64-bit accumulator written back
// - dual subtract sets sticky overflow when the accumulate add overflows
module smac_unit (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [smac_pkg::SMAC_AW-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    output logic sticky_overflow,
    output logic busy
);
    import smac_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_EXEC = 2'b10
    } smac_state_t;

    smac_state_t state;
    smac_wb_req_t req;
    logic wr_stb;
    logic [31:0] rd_word;
    logic [31:0] first_operand;
    logic [31:0] second_operand;
    logic [31:0] accumulate_operand;
    logic [31:0] result_low_word;
    logic [31:0] result_high_word;
    logic [31:0] ctrl;
    logic q;
    logic start;
    logic stat_wr;
    logic cond_ok;
    logic exec_wr;
    smac_dec_t dec;
    smac_halves_t hv;
    smac_res_t next_res;
    logic signed [31:0] p0;
    logic signed [31:0] p1;
    logic signed [47:0] pw;
    logic signed [63:0] pl;
    logic [31:0] diff;
    logic [31:0] sum32;
    logic [63:0] acc64;
    logic [63:0] long_sum;

    assign req = '{cyc: wb_cyc, stb: wb_stb, we: wb_we, adr: wb_adr, sel: wb_sel, dat: wb_dat_w};

    smac_wb_port u_port (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .req(req),
        .rd_word(rd_word),
        .ack(wb_ack),
        .dat_r(wb_dat_r),
        .wr_stb(wr_stb)
    );

    // command strobes decoded from the bus write
    assign start = wr_stb && (req.adr == SMAC_OFS_CTRL) && req.sel[3] && req.dat[SMAC_CTRL_START_BIT];
    assign stat_wr = wr_stb && (req.adr == SMAC_OFS_STAT) && req.sel[0];
    assign cond_ok = ctrl[SMAC_CTRL_COND_BIT];
    assign exec_wr = (state == S_EXEC) && cond_ok;
    assign dec = smac_decode(ctrl[SMAC_CTRL_OP_LSB +: SMAC_CTRL_OP_W]);
    assign acc64 = {result_high_word, result_low_word};

    // read mux; unmapped offsets read as zero
    always_comb begin
        case (req.adr)
            SMAC_OFS_OPA: rd_word = first_operand;
            SMAC_OFS_OPB: rd_word = second_operand;
            SMAC_OFS_ACC: rd_word = accumulate_operand;
            SMAC_OFS_RLO: rd_word = result_low_word;
            SMAC_OFS_RHI: rd_word = result_high_word;
            SMAC_OFS_CTRL: rd_word = ctrl;
            SMAC_OFS_STAT: rd_word = {30'h0, busy, q};
            default: rd_word = SMAC_RST_WORD;
        endcase
    end

    // operand registers, software only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_operand <= SMAC_RST_WORD;
            second_operand <= SMAC_RST_WORD;
            accumulate_operand <= SMAC_RST_WORD;
        end else if (wr_stb) begin
            case (req.adr)
                SMAC_OFS_OPA: first_operand <= smac_merge(first_operand, req.dat, req.sel);
                SMAC_OFS_OPB: second_operand <= smac_merge(second_operand, req.dat, req.sel);
                SMAC_OFS_ACC: accumulate_operand <= smac_merge(accumulate_operand, req.dat, req.sel);
                default: ;
            endcase
        end
    end

    // control word; the start bit is a trigger and never stored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= SMAC_RST_CTRL;
        end else if (wr_stb && req.adr == SMAC_OFS_CTRL) begin
            ctrl <= smac_merge(ctrl, req.dat, req.sel) & 32'h0000_011f;
        end
    end

    // one cycle of execution per start; a start while busy cannot occur since
    // the bus needs two cycles per access
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= S_IDLE;
        end else if (ce) begin
            case (state)
                S_IDLE: begin
                    if (start) begin
                        state <= S_EXEC;
                    end
                end
                S_EXEC: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    assign busy = (state == S_EXEC);
    assign sticky_overflow = q;

    smac_half_pick u_pick (
        .first_operand(first_operand),
        .second_operand(second_operand),
        .dec(dec),
        .halves(hv)
    );

    // shared multipliers: two halfword products, one word-by-half, one word-by-word
    assign p0 = $signed(hv.x0) * $signed(hv.y0);
    assign p1 = $signed(hv.x1) * $signed(hv.y1);
    assign pw = $signed(first_operand) * $signed(hv.y0);
    assign pl = $signed(first_operand) * $signed(second_operand);
    assign diff = p0 - p1; // cannot overflow for 16-bit operands

    // result and overflow per form; the product itself never flags overflow
    always_comb begin
        next_res = '{lo: result_low_word, hi: result_high_word, wr_lo: 1'b0, wr_hi: 1'b0, ovf: 1'b0};
        sum32 = SMAC_RST_WORD;
        long_sum = 64'h0000_0000_0000_0000;
        case (dec.kind)
            KIND_HALF: begin
                sum32 = p0 + accumulate_operand;
                next_res.ovf = smac_ovf32(p0, accumulate_operand, sum32);
            end
            KIND_WORD_HALF: begin
                sum32 = pw[47:16] + accumulate_operand;
                next_res.ovf = smac_ovf32(pw[47:16], accumulate_operand, sum32);
            end
            KIND_DUAL_ADD: begin
                sum32 = p0 + p1 + accumulate_operand; // no flag
            end
            KIND_DUAL_SUB: begin
                sum32 = diff + accumulate_operand;
                next_res.ovf = smac_ovf32(diff, accumulate_operand, sum32);
            end
            KIND_LONG_WORD: long_sum = pl + acc64;
            KIND_LONG_HALF: long_sum = smac_sx64(p0) + acc64;
            KIND_LONG_DUAL_ADD: long_sum = smac_sx64(p0) + smac_sx64(p1) + acc64;
            KIND_LONG_DUAL_SUB: long_sum = smac_sx64(p0) - smac_sx64(p1) + acc64;
            default: ;
        endcase
        case (dec.kind)
            KIND_HALF, KIND_WORD_HALF, KIND_DUAL_ADD, KIND_DUAL_SUB: begin
                next_res.lo = sum32;
                next_res.wr_lo = 1'b1;
            end
            KIND_LONG_WORD, KIND_LONG_HALF, KIND_LONG_DUAL_ADD, KIND_LONG_DUAL_SUB: begin
                next_res.lo = long_sum[31:0];
                next_res.hi = long_sum[63:32]; // no flag
                next_res.wr_lo = 1'b1;
                next_res.wr_hi = 1'b1;
            end
            default: ;
        endcase
    end

    // result words: software may preload them as the long accumulator
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_low_word <= SMAC_RST_WORD;
            result_high_word <= SMAC_RST_WORD;
        end else if (ce) begin
            if (wr_stb && req.adr == SMAC_OFS_RLO) begin
                result_low_word <= smac_merge(result_low_word, req.dat, req.sel);
            end else if (exec_wr && next_res.wr_lo) begin
                result_low_word <= next_res.lo;
            end
            if (wr_stb && req.adr == SMAC_OFS_RHI) begin
                result_high_word <= smac_merge(result_high_word, req.dat, req.sel);
            end else if (exec_wr && next_res.wr_hi) begin
                result_high_word <= next_res.hi;
            end
        end
    end

    // sticky overflow: set wins over a software write, only software lowers it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= 1'b0;
        end else if (ce) begin
            if (exec_wr && next_res.ovf) begin
                q <= 1'b1;
            end else if (stat_wr) begin
                q <= req.dat[SMAC_STAT_Q_BIT];
            end
        end
    end

    // reference products for the checks, built straight from the operands
    logic [31:0] chk_ll;
    logic [31:0] chk_hh;
    logic [31:0] chk_lh;
    logic [31:0] chk_hl;
    logic [47:0] chk_wh;
    logic go;

    // sign-extend first, so every check product is a plain full-width multiply with no width doubt
    function automatic logic [31:0] chk_sx32(input logic [15:0] h);
        return {{16{h[15]}}, h};
    endfunction

    assign chk_ll = chk_sx32(first_operand[15:0]) * chk_sx32(second_operand[15:0]);
    assign chk_hh = chk_sx32(first_operand[31:16]) * chk_sx32(second_operand[31:16]);
    assign chk_lh = chk_sx32(first_operand[15:0]) * chk_sx32(second_operand[31:16]);
    assign chk_hl = chk_sx32(first_operand[31:16]) * chk_sx32(second_operand[15:0]);
    assign chk_wh = {{16{first_operand[31]}}, first_operand} * {{16{second_operand[31]}}, chk_sx32(second_operand[31:16])};
    assign go = (state == S_EXEC) && ce && cond_ok;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_HALF_HIGH_LOW: assert property (
        go && ctrl[4:0] == mac_half_high_low |=> result_low_word == $past(chk_hl + accumulate_operand))
        else $error("half high-low result wrong");

    AST_HALF_IGNORES_UPPER: assert property (
        go && ctrl[4:0] == mac_half_low_low |=> result_low_word == $past(chk_ll + accumulate_operand)
            && $stable(result_high_word))
        else $error("half low-low result depends on unpicked halves");

    AST_WORD_HALF: assert property (
        go && ctrl[4:0] == mac_word_by_high_half |=> result_low_word == $past(chk_wh[47:16] + accumulate_operand))
        else $error("word by half result wrong");

    AST_OVF_SETS_Q: assert property (
        go && (dec.kind == KIND_HALF || dec.kind == KIND_WORD_HALF) && next_res.ovf |=> q && sticky_overflow)
        else $error("accumulate overflow did not set the flag");

    AST_DUAL_ADD: assert property (
        go && ctrl[4:0] == dual_mac_short |=> result_low_word == $past(chk_ll + chk_hh + accumulate_operand))
        else $error("dual add result wrong");

    AST_DUAL_SWAP: assert property (
        go && ctrl[4:0] == dual_mac_short_swapped |=> result_low_word == $past(chk_lh + chk_hl + accumulate_operand))
        else $error("swapped dual add result wrong");

    AST_NO_FLAG_DUAL_LONG: assert property (
        (state == S_EXEC) && ce && (dec.kind == KIND_DUAL_ADD || dec.kind >= KIND_LONG_WORD) && !stat_wr
        |=> $stable(q))
        else $error("flag changed by a form that must not flag");

    AST_LONG_WORD: assert property (
        go && ctrl[4:0] == long_word_mac
        |=> {result_high_word, result_low_word} == $past(smac_sx64(first_operand) * smac_sx64(second_operand) + acc64))
        else $error("long word result wrong");

    AST_LONG_HALF: assert property (
        go && ctrl[4:0] == long_half_mac_high_low
        |=> {result_high_word, result_low_word} == $past(smac_sx64(chk_hl) + acc64))
        else $error("long half result wrong");

    AST_LONG_DUAL: assert property (
        go && ctrl[4:0] == long_dual_mac
        |=> {result_high_word, result_low_word} == $past(smac_sx64(chk_ll) + smac_sx64(chk_hh) + acc64))
        else $error("long dual result wrong");

    AST_DUAL_SUB: assert property (
        go && ctrl[4:0] == dual_mul_sub_short |=> result_low_word == $past(chk_ll - chk_hh + accumulate_operand))
        else $error("dual subtract result wrong");

    AST_LONG_DUAL_SUB: assert property (
        go && ctrl[4:0] == long_dual_mul_sub_swapped
        |=> {result_high_word, result_low_word} == $past(smac_sx64(chk_lh) - smac_sx64(chk_hl) + acc64))
        else $error("long dual subtract result wrong");

    AST_Q_STICKY: assert property (
        q && !stat_wr |=> q)
        else $error("sticky overflow cleared without a software write");

    AST_COND_FAIL: assert property (
        (state == S_EXEC) && ce && !cond_ok
        |=> $stable(result_low_word) && $stable(result_high_word) && $stable(q))
        else $error("failed condition changed state");

    AST_ACK_ONE: assert property (
        wb_ack |=> !wb_ack)
        else $error("ack held longer than one cycle");

    AST_DUAL_SUB_SWAP: assert property (
        go && ctrl[4:0] == dual_mul_sub_short_swapped
        |=> result_low_word == $past(chk_lh - chk_hl + accumulate_operand))
        else $error("swapped dual subtract result wrong");

    AST_SUB_OVF_SETS_Q: assert property (
        go && dec.kind == KIND_DUAL_SUB && next_res.ovf |=> q && sticky_overflow)
        else $error("dual subtract overflow did not set the flag");

    AST_SHORT_KEEPS_HIGH: assert property (
        go && (dec.kind == KIND_HALF || dec.kind == KIND_WORD_HALF || dec.kind == KIND_DUAL_ADD
            || dec.kind == KIND_DUAL_SUB) |=> $stable(result_high_word))
        else $error("a 32-bit form changed the high result word");

    AST_CE_FREEZE: assert property (
        !ce |=> $stable(state) && $stable(result_low_word) && $stable(result_high_word) && $stable(q)
            && $stable(wb_ack))
        else $error("state moved while the clock enable was low");

    AST_BUSY_ONE: assert property (
        busy && ce |=> !busy)
        else $error("execution lasted more than one enabled cycle");
endmodule

// [smac_host.sv]
`timescale 1ns/10ps
// bus master standing in for the decoder and register file
module smac_host (
    input wire logic clk_sys,
    input wire logic wb_ack,
    input wire logic [31:0] wb_dat_r,
    output logic wb_cyc,
    output logic wb_stb,
    output logic wb_we,
    output logic [smac_pkg::SMAC_AW-1:0] wb_adr,
    output logic [3:0] wb_sel,
    output logic [31:0] wb_dat_w
);
    import smac_pkg::*;

    // idle bus at time zero
    initial begin
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = '0;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0;
    end

    // one classic cycle, held until ack is seen at an edge
    task automatic xfer(input logic w, input logic [SMAC_AW-1:0] a, input logic [3:0] s,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a; // operand, result, control and status words, each its own place
        wb_sel <= s;
        wb_dat_w <= d;
        do begin
            @(posedge clk_sys);
        end while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        // stale data must not look valid after release
        wb_dat_w <= ~d;
    endtask
endmodule

// [smac_unit_test.sv]
`timescale 1ns/10ps
module smac_unit_test;
    import smac_pkg::*;
    logic clk_sys, rst, ce, wb_cyc, wb_stb, wb_we, wb_ack, sticky_overflow, busy, q_exp;
    logic [SMAC_AW-1:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rv;
    logic [64:0] m;
    int error_cnt, check_count;
    logic [31:0] va [2] = '{32'h7fff_8001, 32'h0003_fffe};
    logic [31:0] vb [2] = '{32'h8000_7fff, 32'hfffd_0005};
    logic [31:0] vc [2] = '{32'h7fff_fff0, 32'h0000_0010};
    logic [63:0] vl [2] = '{64'h8000_0000_ffff_fff0, 64'h0000_0001_0000_0002};

    smac_unit smac_unit_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .sticky_overflow(sticky_overflow), .busy(busy));
    smac_host smac_host_i (.clk_sys(clk_sys), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w));

    // reference arithmetic, returns {overflow, high word, low word}
    function automatic logic [64:0] mdl(input logic [4:0] op, input logic [31:0] a, input logic [31:0] b,
        input logic [31:0] c, input logic [63:0] l);
        logic signed [15:0] xl, xh, y, ys;
        logic signed [63:0] p;
        logic [31:0] s;
        xl = a[15:0];
        xh = a[31:16];
        y = op[0] ? b[31:16] : b[15:0];
        ys = op[0] ? b[15:0] : b[31:16];
        case (op)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h0c, 5'h0d, 5'h0e, 5'h0f: p = (op[1] ? xh : xl) * y;
            5'h04, 5'h05: p = ($signed(a) * y) >>> 16;
            5'h06, 5'h07, 5'h0a, 5'h0b: p = xl * y + xh * ys;
            5'h10, 5'h11, 5'h12, 5'h13: p = xl * y - xh * ys;
            5'h08: p = $signed(a) * $signed(b);
            default: p = 64'sh0;
        endcase
        if (op > 5'h13) begin
            return {1'b0, l};
        end
        if (op[3] || (op[4] && op[1])) begin
            return {1'b0, l + p};
        end
        s = p[31:0] + c;
        return {(op[4:1] != 4'h3) && (p[31] == c[31]) && (s[31] != c[31]), l[63:32], s};
    endfunction

    task automatic wr(input logic [SMAC_AW-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        smac_host_i.xfer(1'b1, a, 4'hf, d, q);
    endtask

    task automatic rd(input logic [SMAC_AW-1:0] a, output logic [31:0] q);
        smac_host_i.xfer(1'b0, a, 4'h0, 32'h0, q);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // a hung handshake would otherwise stall the run forever
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        error_cnt = 0;
        check_count = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values, last place unmapped
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), rv);
            chk(rv, i == 5 ? SMAC_RST_CTRL : SMAC_RST_WORD);
        end
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, rv);
        chk(rv, 32'h0);
        smac_host_i.xfer(1'b1, SMAC_OFS_OPA, 4'b0010, 32'haabb_ccdd, rv);
        rd(SMAC_OFS_OPA, rv);
        chk(rv, 32'h0000_cc00);
        // codes 0x00 to 0x14 on two operand sets; second set starts with the flag already set
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 21; k++) begin
                wr(SMAC_OFS_OPA, va[s]);
                wr(SMAC_OFS_OPB, vb[s]);
                wr(SMAC_OFS_ACC, vc[s]);
                wr(SMAC_OFS_RLO, vl[s][31:0]);
                wr(SMAC_OFS_RHI, vl[s][63:32]);
                wr(SMAC_OFS_STAT, 32'(s));
                m = mdl(5'(k), va[s], vb[s], vc[s], vl[s]);
                q_exp = s[0] | m[64];
                wr(SMAC_OFS_CTRL, 32'h8000_0100 | 32'(k));
                ce <= 1'b0;
                #1 chk({31'h0, busy}, 32'h1);
                // a low enable must hold the execute cycle and the old flag
                repeat (3) @(posedge clk_sys);
                chk({31'h0, busy}, 32'h1);
                chk({31'h0, sticky_overflow}, 32'(s));
                ce <= 1'b1;
                rd(SMAC_OFS_RLO, rv);
                chk(rv, m[31:0]);
                rd(SMAC_OFS_RHI, rv);
                chk(rv, m[63:32]);
                rd(SMAC_OFS_STAT, rv);
                chk(rv, {31'h0, q_exp});
                chk({31'h0, sticky_overflow}, {31'h0, q_exp});
                rd(SMAC_OFS_CTRL, rv);
                chk(rv, 32'h0000_0100 | 32'(k));
                // a new accumulate would show in the result if a failed condition still ran
                wr(SMAC_OFS_ACC, ~vc[s]);
                wr(SMAC_OFS_STAT, 32'h0);
                wr(SMAC_OFS_CTRL, 32'h8000_0000 | 32'(k));
                rd(SMAC_OFS_RLO, rv);
                chk(rv, m[31:0]);
                rd(SMAC_OFS_RHI, rv);
                chk(rv, m[63:32]);
                rd(SMAC_OFS_STAT, rv);
                chk(rv, 32'h0);
            end
        end
        complete_run();
    end
endmodule
